// ===== rtl/call_clear_decrement_ops.sv
// Execution of indirect call, clears, watchdog kick, invert and decrements.
// Assumes one instruction presented per cycle with file operand already read.
// Function
// - indirect call pushes PC plus one
// - indirect call loads PC from accumulator, latch
// - indirect call two cycles, flags untouched
// - file clear writes zero, sets null flag
// - accumulator clear writes zero, sets flag
// - kick zeroes watchdog counter and prescaler
// - kick sets expiry and sleep flags only
// - invert complements file, updates null flag
// - destination bit selects accumulator or file
// - decrement subtracts one, updates null flag
// - decrement-skip nops next instruction on zero
`timescale 1ns/10ps
`default_nettype none
`include "exec_map.svh"
module call_clear_decrement_ops (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_valid,
	input wire logic [13:0] i_insn,
	input wire logic [14:0] i_pc,
	input wire logic [7:0] i_acc,
	input wire logic [7:0] i_latch,
	input wire logic [7:0] i_file_rd,
	input wire exec_pkg::flags_t i_flags,
	output exec_pkg::flags_t o_flags,
	output logic [7:0] o_acc,
	output exec_pkg::fwrite_t o_fwrite,
	output logic o_push,
	output logic [14:0] o_push_addr,
	output logic o_pc_load,
	output logic [14:0] o_pc,
	output logic o_watchdog_clear,
	output logic o_busy
);
	exec_pkg::op_t op;
	op_decode op_decode_inst (
		.i_insn(i_insn),
		.o_op(op)
	);
	logic flush_r, flush_nxt;
	exec_pkg::flags_t flags_r, flags_nxt;
	logic [7:0] acc_r, acc_nxt;
	exec_pkg::fwrite_t fw_r, fw_nxt;
	logic push_r, pc_load_r, kick_r;
	logic [14:0] push_addr_r, pc_r, push_addr_nxt, pc_nxt;
	// A slot after a call or a taken skip is thrown away whatever it holds
	wire run = i_valid && !flush_r;
	wire dest_file = i_insn[`FLD_DEST];
	wire [6:0] addr = i_insn[`FLD_ADDR_HI:0];
	wire is_call = run && op == exec_pkg::OP_ICALL;
	wire is_kick = run && op == exec_pkg::OP_KICK;
	wire is_fclr = run && op == exec_pkg::OP_FCLR;
	wire is_aclr = run && op == exec_pkg::OP_ACLR;
	wire is_arith = run && (op == exec_pkg::OP_FINV || op == exec_pkg::OP_FDEC ||
		op == exec_pkg::OP_DSZ);
	// One subtractor serves both decrement flavours
	wire [7:0] dec_val = i_file_rd - `ONE_BYTE;
	wire [7:0] result = op == exec_pkg::OP_FINV ? ~i_file_rd : dec_val;
	wire res_zero = result == `ZERO_BYTE;
	wire skip = run && op == exec_pkg::OP_DSZ && res_zero;
	always_comb begin
		flags_nxt = i_flags;
		acc_nxt = i_acc;
		fw_nxt = '{en: 1'b0, addr: addr, data: `ZERO_BYTE};
		if (is_fclr) begin
			fw_nxt.en = 1'b1;
			flags_nxt.zero = 1'b1;
		end
		if (is_aclr) begin
			acc_nxt = `ZERO_BYTE;
			flags_nxt.zero = 1'b1;
		end
		if (is_kick) begin
			flags_nxt.expiry = 1'b1;
			flags_nxt.sleep = 1'b1;
		end
		if (is_arith) begin
			if (dest_file) begin
				fw_nxt.en = 1'b1;
				fw_nxt.data = result;
			end else begin
				acc_nxt = result;
			end
			if (op != exec_pkg::OP_DSZ) begin
				flags_nxt.zero = res_zero;
			end
		end
	end
	assign push_addr_nxt = i_pc + `ONE_PC;
	assign pc_nxt = {i_latch[`LATCH_HI:0], i_acc};
	assign flush_nxt = is_call || skip;
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			flush_r <= 1'b0;
			flags_r <= '0;
			acc_r <= `ZERO_BYTE;
			fw_r <= '0;
			push_r <= 1'b0;
			pc_load_r <= 1'b0;
			kick_r <= 1'b0;
			push_addr_r <= `ZERO_PC;
			pc_r <= `ZERO_PC;
		end else begin
			flush_r <= flush_nxt;
			flags_r <= flags_nxt;
			acc_r <= acc_nxt;
			fw_r <= fw_nxt;
			push_r <= is_call;
			pc_load_r <= is_call;
			kick_r <= is_kick;
			push_addr_r <= push_addr_nxt;
			pc_r <= pc_nxt;
		end
	end
	assign o_flags = flags_r;
	assign o_acc = acc_r;
	assign o_fwrite = fw_r;
	assign o_push = push_r;
	assign o_push_addr = push_addr_r;
	assign o_pc_load = pc_load_r;
	assign o_pc = pc_r;
	assign o_watchdog_clear = kick_r;
	assign o_busy = flush_r;

	call_push_a: assert property (@(posedge i_clk) disable iff (i_srst)
		is_call |=> o_push && o_push_addr == $past(i_pc) + `ONE_PC)
		else $error("return address wrong");
	call_target_a: assert property (@(posedge i_clk) disable iff (i_srst)
		is_call |=> o_pc_load && o_pc == {$past(i_latch[`LATCH_HI:0]), $past(i_acc)})
		else $error("call target wrong");
	call_cycles_a: assert property (@(posedge i_clk) disable iff (i_srst)
		is_call |=> o_busy && o_flags == $past(i_flags) ##1 !o_pc_load)
		else $error("call timing or flags wrong");
	fclear_a: assert property (@(posedge i_clk) disable iff (i_srst)
		is_fclr |=> o_fwrite.en && o_fwrite.data == `ZERO_BYTE && o_flags.zero
		&& o_flags.expiry == $past(i_flags.expiry))
		else $error("file clear wrong");
	aclear_a: assert property (@(posedge i_clk) disable iff (i_srst)
		is_aclr |=> o_acc == `ZERO_BYTE && o_flags.zero && !o_fwrite.en)
		else $error("acc clear wrong");
	kick_wdt_a: assert property (@(posedge i_clk) disable iff (i_srst)
		is_kick |=> o_watchdog_clear ##1 !o_watchdog_clear || $past(is_kick))
		else $error("watchdog kick wrong");
	kick_flags_a: assert property (@(posedge i_clk) disable iff (i_srst)
		is_kick |=> o_flags.expiry && o_flags.sleep && o_flags.zero == $past(i_flags.zero))
		else $error("kick flags wrong");
	dest_a: assert property (@(posedge i_clk) disable iff (i_srst)
		is_arith && dest_file |=> o_fwrite.en && o_acc == $past(i_acc))
		else $error("destination wrong");
	invert_a: assert property (@(posedge i_clk) disable iff (i_srst)
		is_arith && op == exec_pkg::OP_FINV && !dest_file
		|=> o_acc == ~$past(i_file_rd) && o_flags.zero == (o_acc == `ZERO_BYTE))
		else $error("invert wrong");
	decr_a: assert property (@(posedge i_clk) disable iff (i_srst)
		is_arith && op == exec_pkg::OP_FDEC && dest_file
		|=> o_fwrite.data == $past(i_file_rd) - `ONE_BYTE)
		else $error("decrement wrong");
	skip_a: assert property (@(posedge i_clk) disable iff (i_srst)
		run && op == exec_pkg::OP_DSZ |=> o_busy == ($past(i_file_rd) == `ONE_BYTE))
		else $error("skip wrong");

	// A discarded slot must leave every side effect idle
	discard_idle_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_valid && o_busy |=> !o_fwrite.en && !o_push && !o_pc_load
		&& !o_watchdog_clear && o_acc == $past(i_acc))
		else $error("discarded slot acted");
	push_pulse_a: assert property (@(posedge i_clk) disable iff (i_srst)
		o_push
		|=> !o_push)
		else $error("push longer than one cycle");
	target_pulse_a: assert property (@(posedge i_clk) disable iff (i_srst)
		o_pc_load
		|=> !o_pc_load)
		else $error("pc load longer than one cycle");
	call_quiet_a: assert property (@(posedge i_clk) disable iff (i_srst)
		is_call
		|=> !o_fwrite.en && o_acc == $past(i_acc) && !o_watchdog_clear)
		else $error("call touched data");
	fclear_addr_a: assert property (@(posedge i_clk) disable iff (i_srst)
		is_fclr
		|=> o_fwrite.addr == $past(i_insn[`FLD_ADDR_HI:0]) && o_acc == $past(i_acc))
		else $error("file clear address wrong");
	kick_only_a: assert property (@(posedge i_clk) disable iff (i_srst)
		is_kick
		|=> !o_fwrite.en && o_acc == $past(i_acc) && !o_push)
		else $error("kick touched data");
	acc_dest_a: assert property (@(posedge i_clk) disable iff (i_srst)
		is_arith && !dest_file
		|=> !o_fwrite.en)
		else $error("accumulator destination wrote file");
	decr_acc_a: assert property (@(posedge i_clk) disable iff (i_srst)
		run && op == exec_pkg::OP_FDEC && !dest_file
		|=> o_acc == $past(i_file_rd) - `ONE_BYTE && o_flags.zero == ($past(i_file_rd) == `ONE_BYTE))
		else $error("decrement into accumulator wrong");
	invert_file_a: assert property (@(posedge i_clk) disable iff (i_srst)
		run && op == exec_pkg::OP_FINV && dest_file
		|=> o_fwrite.data == ~$past(i_file_rd) && o_flags.zero == (o_fwrite.data == `ZERO_BYTE))
		else $error("invert into file wrong");
	// Decrement-skip reports only through the discarded slot, not the flags
	skip_flags_a: assert property (@(posedge i_clk) disable iff (i_srst)
		run && op == exec_pkg::OP_DSZ
		|=> o_flags == $past(i_flags))
		else $error("skip changed flags");
	busy_len_a: assert property (@(posedge i_clk) disable iff (i_srst)
		o_busy
		|=> !o_busy)
		else $error("two slots discarded");
	// Checked without the disable so the reset value itself is watched
	reset_idle_a: assert property (@(posedge i_clk)
		i_srst
		|=> !o_push && !o_pc_load && !o_busy && !o_fwrite.en && !o_watchdog_clear)
		else $error("outputs active after reset");

	call_c: cover property (@(posedge i_clk) is_call ##1 o_busy);
	skip_c: cover property (@(posedge i_clk) skip);
	kick_c: cover property (@(posedge i_clk) is_kick);
	dec_c: cover property (@(posedge i_clk) is_arith && !skip);
	fclear_c: cover property (@(posedge i_clk) is_fclr ##1 o_fwrite.en);
endmodule
`default_nettype wire

// ===== rtl/exec_map.svh
// Opcode encodings, field positions and widths for the execution unit.
// Assumes a 14-bit instruction word and a 15-bit program counter.
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH
`define OPC_ICALL 14'h000A
`define OPC_ACLR 14'h0100
`define OPC_KICK 14'h0064
`define OPC_TOP_FCLR 7'h03
`define OPC_TOP_FINV 6'h09
`define OPC_TOP_FDEC 6'h03
`define OPC_TOP_DSZ 6'h0B
`define FLD_DEST 7
`define FLD_ADDR_HI 6
`define FLD_TOP6_LO 8
`define FLD_TOP7_LO 7
`define LATCH_HI 6
`define PC_LO_HI 7
`define ZERO_BYTE 8'h00
`define ONE_BYTE 8'h01
`define ZERO_WORD 14'h0000
`define ZERO_PC 15'h0000
`define ONE_PC 15'h0001
`endif

// ===== rtl/exec_pkg.sv
// Types shared by the execution unit.
// Assumes nothing beyond the map header.
package exec_pkg;
	typedef enum logic [2:0] {OP_NONE, OP_ICALL, OP_FCLR, OP_ACLR, OP_KICK, OP_FINV, OP_FDEC, OP_DSZ} op_t;
	typedef struct packed {
		logic zero;
		logic expiry;
		logic sleep;
	} flags_t;
	typedef struct packed {
		logic en;
		logic [6:0] addr;
		logic [7:0] data;
	} fwrite_t;
endpackage

// ===== rtl/op_decode.sv
// Opcode decoder for the execution unit.
// Assumes a 14-bit instruction word.
`timescale 1ns/10ps
`default_nettype none
`include "exec_map.svh"
module op_decode (
	input wire logic [13:0] i_insn,
	output exec_pkg::op_t o_op
);
	wire is_icall = i_insn == `OPC_ICALL;
	wire is_aclr = i_insn == `OPC_ACLR;
	wire is_kick = i_insn == `OPC_KICK;
	wire is_fclr = i_insn[13:`FLD_TOP7_LO] == `OPC_TOP_FCLR;
	wire is_finv = i_insn[13:`FLD_TOP6_LO] == `OPC_TOP_FINV;
	wire is_fdec = i_insn[13:`FLD_TOP6_LO] == `OPC_TOP_FDEC;
	wire is_dsz = i_insn[13:`FLD_TOP6_LO] == `OPC_TOP_DSZ;
	assign o_op = is_icall ? exec_pkg::OP_ICALL :
		is_aclr ? exec_pkg::OP_ACLR :
		is_kick ? exec_pkg::OP_KICK :
		is_fclr ? exec_pkg::OP_FCLR :
		is_finv ? exec_pkg::OP_FINV :
		is_fdec ? exec_pkg::OP_FDEC :
		is_dsz ? exec_pkg::OP_DSZ : exec_pkg::OP_NONE;
endmodule
`default_nettype wire

// ===== bench/call_clear_decrement_ops_test.sv
// Self-checking bench for the execution unit: a table of single ops, then hand cases.
// Assumes each answer appears one edge after an accepted instruction.
`timescale 1ns/10ps
`default_nettype none
module call_clear_decrement_ops_test;
	typedef struct packed {
		logic [13:0] insn;
		logic [7:0] frd;
		logic [2:0] fin;
		logic [2:0] eflg;
		logic [7:0] eacc;
		logic [15:0] efw;
		logic [3:0] ectl;
	} row_t;
	row_t rows [11];
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic valid = 1'b0;
	logic [13:0] insn = 14'h0000;
	logic [7:0] frd = 8'h00;
	logic [2:0] fin = 3'h0;
	exec_pkg::flags_t flg_o;
	exec_pkg::fwrite_t fw_o;
	logic [7:0] acc_o;
	logic [14:0] push_addr;
	logic [14:0] pc_o;
	logic push, pcl, wclr, busy;
	int n_fail = 0;
	int checks_done = 0;
	int cycles = 0;
	call_clear_decrement_ops call_clear_decrement_ops_inst (.i_clk(clk), .i_srst(srst),
		.i_valid(valid), .i_insn(insn), .i_pc(15'h1234), .i_acc(8'h5A), .i_latch(8'hC3),
		.i_file_rd(frd), .i_flags(fin), .o_flags(flg_o), .o_acc(acc_o), .o_fwrite(fw_o),
		.o_push(push), .o_push_addr(push_addr), .o_pc_load(pcl), .o_pc(pc_o),
		.o_watchdog_clear(wclr), .o_busy(busy));
	initial begin
		forever #2 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Second instruction is a clear of the accumulator, offered in the very next slot
	task automatic pair(input logic [13:0] a, input logic [7:0] fa, input logic [7:0] eacc);
		@(posedge clk) #1;
		insn = a;
		frd = fa;
		fin = 3'h0;
		valid = 1'b1;
		@(posedge clk) #1;
		insn = 14'h0100;
		@(posedge clk) #1;
		valid = 1'b0;
		chk(acc_o, eacc);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			n_fail++;
			test_done();
		end
	end
	initial begin
		rows[0] = '{14'h000A, 8'h00, 3'h2, 3'h2, 8'h5A, 16'h0000, 4'hD};
		rows[1] = '{14'h01FF, 8'h33, 3'h3, 3'h7, 8'h5A, 16'hFF00, 4'h0};
		rows[2] = '{14'h0100, 8'h00, 3'h0, 3'h4, 8'h00, 16'h0000, 4'h0};
		rows[3] = '{14'h0064, 8'h00, 3'h4, 3'h7, 8'h5A, 16'h0000, 4'h2};
		rows[4] = '{14'h0905, 8'hFF, 3'h3, 3'h7, 8'h00, 16'h0000, 4'h0};
		rows[5] = '{14'h0990, 8'h0F, 3'h4, 3'h0, 8'h5A, 16'h90F0, 4'h0};
		rows[6] = '{14'h0301, 8'h01, 3'h0, 3'h4, 8'h00, 16'h0000, 4'h0};
		rows[7] = '{14'h03FF, 8'h00, 3'h4, 3'h0, 8'h5A, 16'hFFFF, 4'h0};
		rows[8] = '{14'h0B82, 8'h01, 3'h2, 3'h2, 8'h5A, 16'h8200, 4'h1};
		rows[9] = '{14'h0B02, 8'h05, 3'h5, 3'h5, 8'h04, 16'h0000, 4'h0};
		rows[10] = '{14'h3FFF, 8'h12, 3'h6, 3'h6, 8'h5A, 16'h0000, 4'h0};
		repeat (16) @(posedge clk);
		#1;
		chk({flg_o, acc_o, fw_o, push, pcl, wclr, busy}, 32'h0000_0000);
		srst = 1'b0;
		foreach (rows[i]) begin
			@(posedge clk) #1;
			insn = rows[i].insn;
			frd = rows[i].frd;
			fin = rows[i].fin;
			valid = 1'b1;
			@(posedge clk) #1;
			valid = 1'b0;
			chk(flg_o, rows[i].eflg);
			chk(acc_o, rows[i].eacc);
			chk(rows[i].efw[15] ? fw_o : {fw_o.en, 15'h0000}, rows[i].efw);
			chk({push, pcl, wclr, busy}, rows[i].ectl);
			if (rows[i].ectl[3]) begin
				chk({push_addr, pc_o}, {15'h1235, 15'h435A});
			end
			@(posedge clk);
		end
		pair(14'h000A, 8'h00, 8'h5A);
		pair(14'h0B82, 8'h01, 8'h5A);
		pair(14'h0B82, 8'h07, 8'h00);
		@(posedge clk) #1;
		insn = 14'h000A;
		valid = 1'b1;
		srst = 1'b1;
		@(posedge clk) #1;
		chk({flg_o, acc_o, fw_o, push, pcl, wclr, busy}, 32'h0000_0000);
		srst = 1'b0;
		valid = 1'b0;
		test_done();
	end
endmodule
`default_nettype wire
